// ---- bench/octal_serial_line_controller_bench.sv ----
// self-checking bench of the serial line controller
`timescale 1ns/1ps
`default_nettype none
module octal_serial_line_controller_bench;
   logic clk_i, rst_i, tx_req_i, dma_go_i, bm_ack_i, rxf_rd_i, mctl_wr_i, mst_fifo_en_i;
   logic tx_ie_i, iack_i, tx_ack_o, dma_busy_o, bm_req_o, rxf_empty_o, mst_chg_o;
   logic init_busy_o, irq_o, ub_wr_o, ub_rd_o, uart_irq_i, mlat_we_o;
   logic [2:0] tx_line_i, dma_line_i, mctl_line_i, ub_addr_o, mlat_line_o;
   logic [7:0] tx_char_i, dma_len_i, bm_data_i, mctl_data_i, ub_wdata_o, ub_rdata_i, mlat_data_o;
   logic [21:0] dma_addr_i, bm_addr_o;
   logic [15:0] rxf_data_o, mst_o;
   logic [8:0] vector_o;
   logic [2:0] wa[$];
   logic [7:0] wd[$];
   int error_cnt = 0, checked = 0, npar = 0, i;
   localparam logic [8:0] VBASE = 9'h0C0;
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   osl_ctrl #(.POLL_CYCLES(200)) i_osl_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .tx_req_i(tx_req_i), .tx_line_i(tx_line_i), .tx_char_i(tx_char_i), .tx_ack_o(tx_ack_o),
      .dma_go_i(dma_go_i), .dma_line_i(dma_line_i), .dma_addr_i(dma_addr_i), .dma_len_i(dma_len_i),
      .dma_busy_o(dma_busy_o), .bm_req_o(bm_req_o), .bm_addr_o(bm_addr_o), .bm_ack_i(bm_ack_i),
      .bm_data_i(bm_data_i), .rxf_rd_i(rxf_rd_i), .rxf_data_o(rxf_data_o), .rxf_empty_o(rxf_empty_o),
      .mctl_wr_i(mctl_wr_i), .mctl_line_i(mctl_line_i), .mctl_data_i(mctl_data_i),
      .mst_fifo_en_i(mst_fifo_en_i), .mst_o(mst_o), .mst_chg_o(mst_chg_o), .flow_en_i(1'b0),
      .selftest_i(1'b0), .init_busy_o(init_busy_o), .rx_ie_i(1'b0), .tx_ie_i(tx_ie_i),
      .irq_o(irq_o), .iack_i(iack_i), .vec_base_i(VBASE), .vector_o(vector_o),
      .ub_addr_o(ub_addr_o), .ub_wdata_o(ub_wdata_o), .ub_wr_o(ub_wr_o), .ub_rd_o(ub_rd_o),
      .ub_rdata_i(ub_rdata_i), .uart_irq_i(uart_irq_i), .mlat_we_o(mlat_we_o),
      .mlat_line_o(mlat_line_o), .mlat_data_o(mlat_data_o));
   osl_uart_model i_osl_uart_model (.clk_i(clk_i), .rst_i(rst_i), .ub_addr_i(ub_addr_o),
      .ub_wdata_i(ub_wdata_o), .ub_wr_i(ub_wr_o), .ub_rd_i(ub_rd_o), .ub_rdata_o(ub_rdata_i),
      .uart_irq_o(uart_irq_i));
   // log uart bus writes; count speed writes of the init pass
   always @(posedge clk_i) begin
      if (ub_wr_o) begin
         wa.push_back(ub_addr_o);
         wd.push_back(ub_wdata_o);
         if (init_busy_o && ub_addr_o == osl_pkg::UREG_PAR && ub_wdata_o == osl_pkg::PAR_9600) npar++;
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // a spent bound ends the run at once
   task tmo(input logic ok, input string m);
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: timeout %s", $time, m);
         results;
      end
   endtask
   // scans interleave, so search the log for the pair
   task chk_txd(input logic [2:0] l, input logic [7:0] c);
      int k;
      k = 0;
      while (k + 1 < wa.size() && !(wa[k] == osl_pkg::UREG_IDX && wd[k] == {5'h00, l}
             && wa[k+1] == osl_pkg::UREG_TXD && wd[k+1] == c)) k++;
      chk(16'(k + 1 < wa.size()), 16'h0001, "index then data write");
   endtask
   task pop(input logic [15:0] exp);
      @(posedge clk_i);
      rxf_rd_i <= 1'b1;
      @(posedge clk_i);
      rxf_rd_i <= 1'b0;
      @(negedge clk_i);
      chk(rxf_data_o, exp, "fifo entry");
   endtask
   task t_init;
      for (i = 0; i < 300 && init_busy_o !== 1'b0; i++) @(negedge clk_i);
      tmo(init_busy_o === 1'b0, "init");
      chk(16'(npar), 16'h0008, "speed writes");
      chk(16'(rxf_empty_o), 16'h0001, "fifo empty");
      $display("test init done");
   endtask
   task t_tx(input logic [2:0] l, input logic [7:0] c);
      @(posedge clk_i);
      tx_req_i <= 1'b1;
      tx_line_i <= l;
      tx_char_i <= c;
      @(negedge clk_i);
      for (i = 0; i < 100 && tx_ack_o !== 1'b1; i++) @(negedge clk_i);
      tmo(tx_ack_o === 1'b1, "tx ack");
      @(posedge clk_i);
      tx_req_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_txd(l, c);
      $display("test tx done");
   endtask
   task t_rx;
      @(negedge clk_i);
      i_osl_uart_model.put_rx(3'h3, 8'h5A);
      for (i = 0; i < 300 && rxf_empty_o !== 1'b0; i++) @(negedge clk_i);
      tmo(rxf_empty_o === 1'b0, "rx char");
      pop(16'h035A);
      chk(16'(rxf_empty_o), 16'h0001, "fifo drained");
      chk(16'(i_osl_uart_model.err), 16'h0000, "index before access");
      $display("test rx done");
   endtask
   task t_mctl;
      @(posedge clk_i);
      mctl_wr_i <= 1'b1;
      mctl_line_i <= 3'h4;
      mctl_data_i <= 8'h3C;
      @(posedge clk_i);
      mctl_wr_i <= 1'b0;
      for (i = 0; i < 300 && mlat_we_o !== 1'b1; i++) @(negedge clk_i);
      tmo(mlat_we_o === 1'b1, "latch load");
      chk({5'h00, mlat_line_o, mlat_data_o}, 16'h043C, "latch value");
      $display("test modem control done");
   endtask
   task t_dma;
      @(posedge clk_i);
      tx_ie_i <= 1'b1;
      dma_go_i <= 1'b1;
      dma_line_i <= 3'h1;
      dma_addr_i <= 22'h000100;
      dma_len_i <= 8'h02;
      @(posedge clk_i);
      dma_go_i <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(negedge clk_i);
         for (i = 0; i < 200 && bm_req_o !== 1'b1; i++) @(negedge clk_i);
         tmo(bm_req_o === 1'b1, "bus request");
         chk(bm_addr_o[15:0], 16'h0100 + 16'(k), "dma address");
         repeat (3 * k + 1) @(posedge clk_i);
         bm_ack_i <= 1'b1;
         bm_data_i <= 8'hC0 + 8'(k);
         @(posedge clk_i);
         bm_ack_i <= 1'b0;
      end
      for (i = 0; i < 200 && dma_busy_o !== 1'b0; i++) @(negedge clk_i);
      tmo(dma_busy_o === 1'b0, "dma end");
      repeat (3) @(posedge clk_i);
      chk_txd(3'h1, 8'hC0);
      chk_txd(3'h1, 8'hC1);
      @(negedge clk_i);
      chk(16'(irq_o), 16'h0001, "tx interrupt");
      @(posedge clk_i);
      iack_i <= 1'b1;
      @(posedge clk_i);
      iack_i <= 1'b0;
      @(negedge clk_i);
      chk({7'h00, vector_o}, {7'h00, VBASE + osl_pkg::VEC_TX_OFS}, "vector");
      chk(16'(irq_o), 16'h0000, "interrupt cleared");
      $display("test dma done");
   endtask
   task t_mst;
      @(posedge clk_i);
      mst_fifo_en_i <= 1'b1;
      @(negedge clk_i);
      i_osl_uart_model.set_mst(3'h2, 8'hA5);
      for (i = 0; i < 1000 && mst_chg_o !== 1'b1; i++) @(negedge clk_i);
      tmo(mst_chg_o === 1'b1, "status change");
      chk(mst_o, 16'h02A5, "status report");
      for (i = 0; i < 100 && rxf_empty_o !== 1'b0; i++) @(negedge clk_i);
      tmo(rxf_empty_o === 1'b0, "status entry");
      pop(16'h82A5);
      $display("test modem status done");
   endtask
   initial begin
      rst_i = 1'b1;
      {tx_req_i, dma_go_i, bm_ack_i, rxf_rd_i, mctl_wr_i, mst_fifo_en_i, tx_ie_i, iack_i} = '0;
      {tx_line_i, tx_char_i, dma_line_i, dma_addr_i, dma_len_i, bm_data_i} = '0;
      {mctl_line_i, mctl_data_i} = '0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_init;
      t_tx(3'h5, 8'h41);
      t_tx(3'h6, 8'hE7);
      t_rx;
      t_mctl;
      t_dma;
      t_mst;
      results;
   end
endmodule // octal_serial_line_controller_bench
`default_nettype wire

// ---- bench/osl_chk.sv ----
// assertion checker watching the serial line controller ports
`timescale 1ns/1ps
`default_nettype none
module osl_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_ack_o,
   input wire logic [2:0] tx_line_i,
   input wire logic [7:0] tx_char_i,
   input wire logic [2:0] ub_addr_o,
   input wire logic [7:0] ub_wdata_o,
   input wire logic ub_wr_o,
   input wire logic ub_rd_o,
   input wire logic init_busy_o,
   input wire logic bm_req_o,
   input wire logic bm_ack_i,
   input wire logic [21:0] bm_addr_o,
   input wire logic rxf_empty_o,
   input wire logic rxf_rd_i,
   input wire logic mst_chg_o,
   input wire logic [15:0] mst_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // host character: index write next cycle, data write the cycle after
   property p_tx_idx;
      tx_ack_o |=> ub_wr_o && ub_addr_o == osl_pkg::UREG_IDX && ub_wdata_o == {5'h00, $past(tx_line_i)};
   endproperty
   a_tx_idx: assert property (p_tx_idx) else $error("no index write after tx");
   property p_tx_dat;
      tx_ack_o |-> ##2 ub_wr_o && ub_addr_o == osl_pkg::UREG_TXD && ub_wdata_o == $past(tx_char_i, 2);
   endproperty
   a_tx_dat: assert property (p_tx_dat) else $error("tx data write wrong");
   // shared bus has a single driver in any cycle
   property p_one_drv;
      !(ub_wr_o && ub_rd_o);
   endproperty
   a_one_drv: assert property (p_one_drv) else $error("read and write together");
   property p_wr_map;
      ub_wr_o |-> !ub_addr_o[2];
   endproperty
   a_wr_map: assert property (p_wr_map) else $error("write to read-only reg");
   property p_rd_map;
      ub_rd_o |-> ub_addr_o[2];
   endproperty
   a_rd_map: assert property (p_rd_map) else $error("read of write-only reg");
   property p_baud;
      init_busy_o && ub_wr_o && ub_addr_o == osl_pkg::UREG_PAR |-> ub_wdata_o == osl_pkg::PAR_9600;
   endproperty
   a_baud: assert property (p_baud) else $error("init speed wrong");
   property p_idx_first;
      ub_rd_o && ub_addr_o == osl_pkg::UREG_RXD |-> $past(ub_wr_o) && $past(ub_addr_o) == osl_pkg::UREG_IDX;
   endproperty
   a_idx_first: assert property (p_idx_first) else $error("rx read without index");
   // request and address stand until the host bus answers
   property p_bm_hold;
      bm_req_o && !bm_ack_i |=> bm_req_o && $stable(bm_addr_o);
   endproperty
   a_bm_hold: assert property (p_bm_hold) else $error("bus request dropped");
   property p_empty_pop;
      $rose(rxf_empty_o) |-> $past(rxf_rd_i);
   endproperty
   a_empty_pop: assert property (p_empty_pop) else $error("fifo emptied itself");
   property p_mst_fmt;
      mst_chg_o |-> mst_o[15:11] == 5'h00;
   endproperty
   a_mst_fmt: assert property (p_mst_fmt) else $error("status format wrong");
   c_tx: cover property (tx_ack_o);
   c_rx: cover property (ub_rd_o && ub_addr_o == osl_pkg::UREG_RXD);
   c_mst: cover property (mst_chg_o);
endmodule // osl_chk
bind osl_ctrl osl_chk i_osl_chk (.clk_i(clk_i), .rst_i(rst_i), .tx_ack_o(tx_ack_o),
   .tx_line_i(tx_line_i), .tx_char_i(tx_char_i), .ub_addr_o(ub_addr_o), .ub_wdata_o(ub_wdata_o),
   .ub_wr_o(ub_wr_o), .ub_rd_o(ub_rd_o), .init_busy_o(init_busy_o), .bm_req_o(bm_req_o),
   .bm_ack_i(bm_ack_i), .bm_addr_o(bm_addr_o), .rxf_empty_o(rxf_empty_o), .rxf_rd_i(rxf_rd_i),
   .mst_chg_o(mst_chg_o), .mst_o(mst_o));
`default_nettype wire

// ---- bench/osl_uart_model.sv ----
// behavioural model of the eight channel uart on the shared bus
`timescale 1ns/1ps
`default_nettype none
module osl_uart_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] ub_addr_i,
   input wire logic [7:0] ub_wdata_i,
   input wire logic ub_wr_i,
   input wire logic ub_rd_i,
   output logic [7:0] ub_rdata_o,
   output logic uart_irq_o
);
   logic [2:0] idx;
   logic [2:0] pend_line;
   logic [7:0] pend_chr;
   logic [7:0] mst [8];
   int err;
   // bench hooks, called away from the clock edge
   task put_rx(input logic [2:0] l, input logic [7:0] c);
      pend_line = l;
      pend_chr = c;
      uart_irq_o = 1'b1;
   endtask
   task set_mst(input logic [2:0] l, input logic [7:0] v);
      mst[l] = v;
   endtask
   // write-only regs below 4, read-only above; idle bus toggles so no stale value reads ok
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         idx <= 3'h0;
         uart_irq_o <= 1'b0;
         ub_rdata_o <= 8'h00;
         err = 0;
         for (int k = 0; k < 8; k++) mst[k] = 8'h00;
      end else begin
         ub_rdata_o <= ~ub_rdata_o;
         if (ub_wr_i && ub_addr_i == osl_pkg::UREG_IDX) idx <= ub_wdata_i[2:0];
         if (ub_rd_i) begin
            case (ub_addr_i)
               osl_pkg::UREG_ILN: ub_rdata_o <= {5'h00, pend_line};
               osl_pkg::UREG_RXD: begin
                  ub_rdata_o <= ~pend_chr;
                  uart_irq_o <= 1'b0;
                  if (idx !== pend_line) err++;
               end
               osl_pkg::UREG_MST: ub_rdata_o <= ~mst[idx];
               default: ;
            endcase
         end
      end
   end
endmodule // osl_uart_model
`default_nettype wire

// ---- logic/osl_ctrl.sv ----
// sequencing and control logic of the octal serial line controller
`timescale 1ns/1ps
`default_nettype none
module osl_ctrl #(
   parameter int POLL_CYCLES = osl_pkg::POLL_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic tx_req_i,
   input wire logic [2:0] tx_line_i,
   input wire logic [7:0] tx_char_i,
   output logic tx_ack_o,
   input wire logic dma_go_i,
   input wire logic [2:0] dma_line_i,
   input wire logic [21:0] dma_addr_i,
   input wire logic [7:0] dma_len_i,
   output logic dma_busy_o,
   output logic bm_req_o,
   output logic [21:0] bm_addr_o,
   input wire logic bm_ack_i,
   input wire logic [7:0] bm_data_i,
   input wire logic rxf_rd_i,
   output logic [15:0] rxf_data_o,
   output logic rxf_empty_o,
   input wire logic mctl_wr_i,
   input wire logic [2:0] mctl_line_i,
   input wire logic [7:0] mctl_data_i,
   input wire logic mst_fifo_en_i,
   output logic [15:0] mst_o,
   output logic mst_chg_o,
   input wire logic flow_en_i,
   input wire logic selftest_i,
   output logic init_busy_o,
   input wire logic rx_ie_i,
   input wire logic tx_ie_i,
   output logic irq_o,
   input wire logic iack_i,
   input wire logic [8:0] vec_base_i,
   output logic [8:0] vector_o,
   output logic [2:0] ub_addr_o,
   output logic [7:0] ub_wdata_o,
   output logic ub_wr_o,
   output logic ub_rd_o,
   input wire logic [7:0] ub_rdata_i,
   input wire logic uart_irq_i,
   output logic mlat_we_o,
   output logic [2:0] mlat_line_o,
   output logic [7:0] mlat_data_o
);
   localparam int NL = osl_pkg::NLINES;
   localparam int PW = $clog2(POLL_CYCLES + 1);

   // lowest pending line, used for latch loads
   function automatic logic [2:0] first1(input logic [NL-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = NL - 1; i >= 0; i--) begin
         if (v[i]) r = 3'(i);
      end
      return r;
   endfunction

   osl_pkg::osl_state_t st, next_st;
   logic [2:0] lin, next_lin, mv, next_mv;
   logic [7:0] chr, next_chr, cnt, next_cnt;
   logic [21:0] next_bm_addr;
   logic [2:0] dline, next_dline;
   logic src_dma, next_src_dma, dma_act, next_dma_act, init_req, next_init_req;
   logic loop, next_loop, txdone, next_txdone, scan_pend, next_scan_pend;
   logic [NL-1:0] stop, next_stop, mpend, next_mpend;
   logic [2:0] next_ub_addr;
   logic [7:0] next_ub_wdata;
   logic next_ub_wr, next_ub_rd, next_mlat_we;
   logic [2:0] next_mlat_line;
   logic [7:0] next_mlat_data;
   logic [15:0] next_mst;
   logic next_mst_chg;
   logic [PW-1:0] poll, next_poll;
   // shared ram: holding areas, modem values and the receive fifo
   logic [7:0] hold_mem [NL*osl_pkg::HOLD_DEPTH];
   logic [7:0] mctl_mem [NL];
   logic [7:0] mst_mem [NL];
   logic [15:0] fifo_mem [osl_pkg::FIFO_DEPTH];
   logic [NL-1:0][1:0] hwr, next_hwr, hrd, next_hrd;
   logic [NL-1:0][2:0] hcnt, next_hcnt;
   logic [7:0] fwr, next_fwr, frd, next_frd;
   logic [8:0] fcnt, next_fcnt;
   logic hold_we, push, mst_we, pop;
   logic [15:0] push_data;
   logic [15:0] next_rxf_data;
   logic [8:0] next_vector;
   logic ffull, hfull;

   assign ffull = (fcnt == 9'(osl_pkg::FIFO_DEPTH));
   assign hfull = (hcnt[lin] == 3'(osl_pkg::HOLD_DEPTH));
   assign rxf_empty_o = (fcnt == 9'h000);
   assign pop = rxf_rd_i && !rxf_empty_o;
   assign bm_req_o = (st == osl_pkg::S_DMA_REQ);
   assign dma_busy_o = dma_act;
   assign init_busy_o = init_req;
   assign irq_o = (rx_ie_i && !rxf_empty_o) || (tx_ie_i && txdone);
   assign tx_ack_o = (st == osl_pkg::S_IDLE) && !init_req && !uart_irq_i && (mpend == '0)
      && !scan_pend && tx_req_i && !stop[tx_line_i];

   // sequencer: one grant at a time keeps the shared bus single-driver
   always_comb begin
      next_st = st; next_lin = lin; next_mv = mv; next_chr = chr; next_cnt = cnt;
      next_bm_addr = bm_addr_o; next_dline = dline; next_src_dma = src_dma;
      next_dma_act = dma_act; next_init_req = init_req; next_loop = loop;
      next_txdone = txdone; next_stop = stop; next_mpend = mpend;
      next_ub_addr = ub_addr_o; next_ub_wdata = ub_wdata_o;
      next_ub_wr = 1'b0; next_ub_rd = 1'b0; next_mlat_we = 1'b0;
      next_mlat_line = mlat_line_o; next_mlat_data = mlat_data_o;
      next_mst = mst_o; next_mst_chg = 1'b0;
      next_hwr = hwr; next_hrd = hrd; next_hcnt = hcnt;
      next_fwr = fwr; next_frd = frd; next_fcnt = fcnt;
      hold_we = 1'b0; push = 1'b0; mst_we = 1'b0; push_data = 16'h0000;
      next_scan_pend = scan_pend;
      next_poll = poll;
      // 10 ms status poll timer
      if (poll == PW'(POLL_CYCLES - 1)) begin
         next_poll = '0;
         next_scan_pend = 1'b1;
      end else begin
         next_poll = poll + PW'(1);
      end
      if (mctl_wr_i) next_mpend[mctl_line_i] = 1'b1;
      if (dma_go_i && !dma_act && dma_len_i != 8'h00) begin
         next_dma_act = 1'b1;
         next_bm_addr = dma_addr_i;
         next_cnt = dma_len_i;
         next_dline = dma_line_i;
      end
      if (selftest_i && st == osl_pkg::S_IDLE) begin
         next_init_req = 1'b1;
         next_loop = 1'b1;
      end
      unique case (st)
         osl_pkg::S_INIT_IX: begin
            next_ub_addr = osl_pkg::UREG_IDX; next_ub_wdata = {5'h00, lin}; next_ub_wr = 1'b1;
            next_hcnt[lin] = 3'h0; next_hwr[lin] = 2'h0; next_hrd[lin] = 2'h0;
            mst_we = 1'b1; next_st = osl_pkg::S_INIT_PAR;
         end
         osl_pkg::S_INIT_PAR: begin
            // every line starts at 9600, set independently per line
            next_ub_addr = osl_pkg::UREG_PAR; next_ub_wdata = osl_pkg::PAR_9600;
            next_ub_wr = 1'b1;
            next_st = osl_pkg::S_INIT_CTL;
         end
         osl_pkg::S_INIT_CTL: begin
            // self-test runs the same pass with the uart looped back
            next_ub_addr = osl_pkg::UREG_CTL;
            next_ub_wdata = loop ? osl_pkg::CTL_LOOP : 8'h00;
            next_ub_wr = 1'b1;
            next_lin = lin + 3'h1; next_st = osl_pkg::S_INIT_IX;
            if (lin == 3'(NL - 1)) begin
               next_st = osl_pkg::S_IDLE;
               next_init_req = 1'b0;
               next_loop = 1'b0;
               next_fwr = 8'h00; next_frd = 8'h00; next_fcnt = 9'h000;
            end
         end
         osl_pkg::S_IDLE: begin
            // fixed priority arbiter
            if (init_req) begin
               next_lin = 3'h0; next_st = osl_pkg::S_INIT_IX;
            end else if (uart_irq_i) begin
               next_ub_addr = osl_pkg::UREG_ILN; next_ub_rd = 1'b1; next_st = osl_pkg::S_RX_WL;
            end else if (mpend != '0) begin
               next_lin = first1(mpend); next_st = osl_pkg::S_ML;
            end else if (scan_pend) begin
               next_scan_pend = 1'b0; next_lin = 3'h0; next_st = osl_pkg::S_MS_IX;
            end else if (tx_ack_o) begin
               next_ub_addr = osl_pkg::UREG_IDX; next_ub_wdata = {5'h00, tx_line_i};
               next_ub_wr = 1'b1; next_chr = tx_char_i; next_src_dma = 1'b0;
               next_st = osl_pkg::S_TX_WR;
            end else if (dma_act && !stop[dline]) begin
               next_st = osl_pkg::S_DMA_REQ;
            end else begin
               // drain oldest holding char only when the fifo has room
               next_mv = mv + 3'h1;
               if (hcnt[mv] != 3'h0 && !ffull) begin
                  push = 1'b1;
                  push_data = {5'h00, mv, hold_mem[{mv, hrd[mv]}]};
                  next_hrd[mv] = hrd[mv] + 2'h1;
                  next_hcnt[mv] = hcnt[mv] - 3'h1;
               end
            end
         end
         osl_pkg::S_RX_WL: next_st = osl_pkg::S_RX_LN;
         osl_pkg::S_RX_LN: begin
            next_lin = ub_rdata_i[2:0];
            next_ub_addr = osl_pkg::UREG_IDX; next_ub_wdata = {5'h00, ub_rdata_i[2:0]};
            next_ub_wr = 1'b1;
            next_st = osl_pkg::S_RX_RD;
         end
         osl_pkg::S_RX_RD: begin
            next_ub_addr = osl_pkg::UREG_RXD; next_ub_rd = 1'b1; next_st = osl_pkg::S_RX_WD;
         end
         osl_pkg::S_RX_WD: next_st = osl_pkg::S_RX_CAP;
         osl_pkg::S_RX_CAP: begin
            // receivers invert the line, so the character is inverted back
            next_chr = ~ub_rdata_i;
            if (!hfull) begin // a full area drops the newest character
               hold_we = 1'b1;
               next_hwr[lin] = hwr[lin] + 2'h1;
               next_hcnt[lin] = hcnt[lin] + 3'h1;
            end
            if (flow_en_i && ~ub_rdata_i == osl_pkg::CHR_XOFF) next_stop[lin] = 1'b1;
            if (flow_en_i && ~ub_rdata_i == osl_pkg::CHR_XON) next_stop[lin] = 1'b0;
            next_st = osl_pkg::S_IDLE;
         end
         osl_pkg::S_ML: begin
            next_mlat_we = 1'b1; next_mlat_line = lin; next_mlat_data = mctl_mem[lin];
            next_mpend[lin] = mctl_wr_i && mctl_line_i == lin;
            next_st = osl_pkg::S_IDLE;
         end
         osl_pkg::S_MS_IX: begin
            next_ub_addr = osl_pkg::UREG_IDX; next_ub_wdata = {5'h00, lin};
            next_ub_wr = 1'b1; next_st = osl_pkg::S_MS_RD;
         end
         osl_pkg::S_MS_RD: begin
            next_ub_addr = osl_pkg::UREG_MST; next_ub_rd = 1'b1; next_st = osl_pkg::S_MS_WT;
         end
         osl_pkg::S_MS_WT: next_st = osl_pkg::S_MS_CMP;
         osl_pkg::S_MS_CMP: begin
            if (~ub_rdata_i != mst_mem[lin]) begin
               mst_we = 1'b1;
               next_mst = {5'h00, lin, ~ub_rdata_i};
               next_mst_chg = 1'b1;
               if (mst_fifo_en_i && !ffull) begin
                  push = 1'b1;
                  push_data = {1'b1, 4'h0, lin, ~ub_rdata_i};
               end
            end
            next_lin = lin + 3'h1;
            next_st = (lin == 3'(NL - 1)) ? osl_pkg::S_IDLE : osl_pkg::S_MS_IX;
         end
         osl_pkg::S_DMA_REQ: begin
            if (bm_ack_i) begin
               next_chr = bm_data_i; next_src_dma = 1'b1;
               next_ub_addr = osl_pkg::UREG_IDX; next_ub_wdata = {5'h00, dline};
               next_ub_wr = 1'b1; next_st = osl_pkg::S_TX_WR;
            end
         end
         osl_pkg::S_TX_WR: begin
            next_ub_addr = osl_pkg::UREG_TXD; next_ub_wdata = chr; next_ub_wr = 1'b1;
            if (src_dma) begin
               next_bm_addr = bm_addr_o + 22'h1;
               next_cnt = cnt - 8'h01;
               if (cnt == 8'h01) begin
                  next_dma_act = 1'b0;
                  next_txdone = 1'b1;
               end
            end
            next_st = osl_pkg::S_IDLE;
         end
         default: next_st = osl_pkg::S_IDLE;
      endcase
      if (push) begin
         next_fwr = fwr + 8'h01;
      end
      if (pop) begin
         next_frd = frd + 8'h01;
      end
      next_fcnt = next_fcnt + {8'h00, push} - {8'h00, pop};
      next_rxf_data = pop ? fifo_mem[frd] : rxf_data_o;
      // acknowledge: receive takes precedence; a new dma completion survives the clear
      next_vector = vector_o;
      if (iack_i) begin
         if (rx_ie_i && !rxf_empty_o) begin
            next_vector = vec_base_i;
         end else begin
            next_vector = vec_base_i + osl_pkg::VEC_TX_OFS;
            if (!(st == osl_pkg::S_TX_WR && src_dma && cnt == 8'h01)) next_txdone = 1'b0;
         end
      end
   end

   // state registers; ce low freezes everything
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= osl_pkg::S_INIT_IX; lin <= 3'h0; mv <= 3'h0; chr <= 8'h00; cnt <= 8'h00;
         bm_addr_o <= 22'h0; dline <= 3'h0; src_dma <= 1'b0; dma_act <= 1'b0;
         init_req <= 1'b1; loop <= 1'b0; txdone <= 1'b0; scan_pend <= 1'b0;
         stop <= '0; mpend <= '0; poll <= '0;
         ub_addr_o <= 3'h0; ub_wdata_o <= 8'h00; ub_wr_o <= 1'b0; ub_rd_o <= 1'b0;
         mlat_we_o <= 1'b0; mlat_line_o <= 3'h0; mlat_data_o <= 8'h00;
         mst_o <= 16'h0000; mst_chg_o <= 1'b0; rxf_data_o <= 16'h0000; vector_o <= 9'h000;
         hwr <= '0; hrd <= '0; hcnt <= '0; fwr <= 8'h00; frd <= 8'h00; fcnt <= 9'h000;
      end else if (ce_i) begin
         st <= next_st; lin <= next_lin; mv <= next_mv; chr <= next_chr; cnt <= next_cnt;
         bm_addr_o <= next_bm_addr; dline <= next_dline; src_dma <= next_src_dma;
         dma_act <= next_dma_act; init_req <= next_init_req; loop <= next_loop;
         txdone <= next_txdone; scan_pend <= next_scan_pend;
         stop <= next_stop; mpend <= next_mpend; poll <= next_poll;
         ub_addr_o <= next_ub_addr; ub_wdata_o <= next_ub_wdata;
         ub_wr_o <= next_ub_wr; ub_rd_o <= next_ub_rd;
         mlat_we_o <= next_mlat_we; mlat_line_o <= next_mlat_line; mlat_data_o <= next_mlat_data;
         mst_o <= next_mst; mst_chg_o <= next_mst_chg; rxf_data_o <= next_rxf_data;
         vector_o <= next_vector;
         hwr <= next_hwr; hrd <= next_hrd; hcnt <= next_hcnt;
         fwr <= next_fwr; frd <= next_frd; fcnt <= next_fcnt;
      end
   end

   // ram arrays carry no reset; fill state alone says what is valid
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (hold_we) hold_mem[{lin, hwr[lin]}] <= next_chr;
         if (push) fifo_mem[fwr] <= push_data;
         if (mctl_wr_i) mctl_mem[mctl_line_i] <= mctl_data_i;
         if (mst_we) mst_mem[lin] <= init_req ? 8'h00 : ~ub_rdata_i;
      end
   end
endmodule // osl_ctrl
`default_nettype wire

// ---- logic/osl_pkg.sv ----
// constants and shared types of the octal serial line controller
// Contract
// - single characters go out by host writes, and by dma from host memory
// - on uart interrupt, the received character goes into that line's 4-char area
// - oldest holding character moves later into the shared 256 x 16 receive fifo
// - modem control latches sit outside; sequencer loads them from stored values
// - modem status sampled every 10 ms; changes reported by status, optionally fifo
// - host side decodes access, raises interrupts, supplies vector on acknowledge
// - one data sequencer performs every host read and write access; receive fifo reads and modem control stores bypass it here
// - uart sequencers move characters both ways and perform per-line flow control
// - power-up sets every line to 9600 baud; same sequencer runs self-test
// - dma sequencer starts and manages dma transfers as bus master
// - arbiter grants shared ram and uart bus to one sequencer at a time
// - eight independent uart channels convert parallel and serial data
// - uart reached through eight registers, four read-only, four write-only
// - uart holds 16-output baud generator, line parameters and loopback
// - uart, control logic and ram share one bus, one driver at a time
// - each line speed is programmed independently, one of 16 rates
// - line receivers invert signals; the logic inverts them back
package osl_pkg;
   localparam int NLINES = 8;
   localparam int HOLD_DEPTH = 4;
   localparam int FIFO_DEPTH = 256;
   // uart register map: write-only 0..3, read-only 4..7
   localparam logic [2:0] UREG_IDX = 3'h0;
   localparam logic [2:0] UREG_TXD = 3'h1;
   localparam logic [2:0] UREG_PAR = 3'h2;
   localparam logic [2:0] UREG_CTL = 3'h3;
   localparam logic [2:0] UREG_RXD = 3'h4;
   localparam logic [2:0] UREG_ILN = 3'h5;
   localparam logic [2:0] UREG_MST = 3'h6;
   localparam logic [2:0] UREG_IST = 3'h7;
   // parameter register: speed code in bits 3:0
   localparam logic [7:0] PAR_9600 = 8'h0D;
   localparam logic [7:0] CTL_LOOP = 8'h01;
   localparam logic [7:0] CHR_XON = 8'h11;
   localparam logic [7:0] CHR_XOFF = 8'h13;
   // receive fifo entry: bit 15 marks a modem status entry, line in 10:8
   localparam int ENT_MST_BIT = 15;
   localparam logic [8:0] VEC_TX_OFS = 9'h004;
   localparam int CLK_MHZ = 250;
   localparam int POLL_MS = 10;
   localparam int POLL_CYC = POLL_MS * CLK_MHZ * 1000;
   typedef enum logic [4:0] {
      S_INIT_IX = 5'h00, S_INIT_PAR = 5'h01, S_INIT_CTL = 5'h02, S_IDLE = 5'h03,
      S_RX_WL = 5'h04, S_RX_LN = 5'h05, S_RX_RD = 5'h06, S_RX_WD = 5'h07,
      S_RX_CAP = 5'h08, S_ML = 5'h09, S_MS_IX = 5'h0A, S_MS_RD = 5'h0B,
      S_MS_WT = 5'h0C, S_MS_CMP = 5'h0D, S_TX_WR = 5'h0E, S_DMA_REQ = 5'h0F
   } osl_state_t;
endpackage
